// file: core/rfs_top.sv
// Reference frequency supervisor: keypad reference retention, analog command loss, low torque flag, jump bands.
// Assumes all inputs synchronous to clk and a plain register port driven by a non-waiting master.
//
// Summary of operation
// - Save mode 0 stores keypad reference at power-off and restores it at power-on.
// - Save mode 1 stores only on save key; unsaved value lost at power cycle.
// - Command below 10% of sampled level within 400 ms means broken wire; run at ratio times reference.
// - After loss, command above ratio-set level means wire repaired; follow command again.
// - Command level is sampled periodically and monitored continuously.
// - Ratio 999 still raises the loss flag but keeps following the command.
// - Ratio 0 or 999 uses 0.2 times sampled level as recovery threshold.
// - Ratio 100% or more, other than 999, uses the full sampled level as recovery threshold.
// - Loss detection uses the unfiltered command level.
// - Low torque flag rises when torque stays below level longer than timer.
// - While running, low torque flag falls only when torque exceeds level plus 5%.
// - While running, each low torque flag pulse lasts at least 100 ms.
// - Low torque level of 100% equals rated motor torque.
// - Below 20% of base frequency low torque evaluation is suspended and flag held.
// - Low torque flag is forced off while the drive is stopped.
// - Reference held at band bottom rising, band top falling, until it leaves the band.
// - Overlapping jump bands merge into one band from lowest bottom to highest top.
// - Three jump centers 0.0 to 120.0 Hz; center 0.0 disables that band.
// - Shared band width 0.0 to 30.0 Hz; width 0.0 disables all bands.
`timescale 1ns/1ps
`include "rfs_map.svh"

module rfs_top #(
	parameter int CYC_PER_MS = `RFS_CLK_HZ / 1000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire rfs_pkg::rfs_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output rfs_pkg::rfs_word_t reg_rdata,
	input wire rfs_pkg::rfs_freq_t cmd_level,
	input wire logic [10:0] torque,
	input wire rfs_pkg::rfs_freq_t out_freq,
	input wire logic running,
	input wire logic save_key,
	input wire logic power_cycle,
	output rfs_pkg::rfs_freq_t ref_out,
	output logic cmd_loss_flag,
	output logic low_torque_flag
);
	import rfs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic ref_save_mode;
	logic src_analog;
	rfs_freq_t keypad_ref;
	rfs_freq_t stored_ref;
	logic [9:0] loss_fallback_ratio;
	logic [10:0] low_torque_level;
	logic [15:0] low_torque_timer;
	rfs_freq_t base_frequency_setting;
	rfs_freq_t jump_center [3];
	rfs_freq_t jump_band_width;
	rfs_freq_t sampled_command_level;
	rfs_loss_t loss_state;

	wire wr_ctrl = reg_wr && reg_addr == `RFS_A_CTRL;
	wire wr_key = reg_wr && reg_addr == `RFS_A_KEYREF;
	wire wr_ratio = reg_wr && reg_addr == `RFS_A_RATIO;
	wire wr_ltl = reg_wr && reg_addr == `RFS_A_LTLEVEL;
	wire wr_ltt = reg_wr && reg_addr == `RFS_A_LTTIMER;
	wire wr_base = reg_wr && reg_addr == `RFS_A_BASEF;
	wire wr_jbw = reg_wr && reg_addr == `RFS_A_JBW;
	wire rfs_freq_t wfreq = reg_wdata[11:0];
	// Out-of-range jump center and band width settings are clipped rather than refused
	wire rfs_freq_t wjc = (wfreq > `RFS_JUMP_MAX) ? `RFS_JUMP_MAX : wfreq;
	wire rfs_freq_t wjbw = (wfreq > `RFS_JBW_MAX) ? `RFS_JBW_MAX : wfreq;

	rfs_word_t rd_mux;
	always_comb begin
		case (reg_addr)
			`RFS_A_CTRL: rd_mux = {14'h0000, src_analog, ref_save_mode};
			`RFS_A_KEYREF: rd_mux = {4'h0, keypad_ref};
			`RFS_A_RATIO: rd_mux = {6'h00, loss_fallback_ratio};
			`RFS_A_LTLEVEL: rd_mux = {5'h00, low_torque_level};
			`RFS_A_LTTIMER: rd_mux = low_torque_timer;
			`RFS_A_BASEF: rd_mux = {4'h0, base_frequency_setting};
			`RFS_A_JC1: rd_mux = {4'h0, jump_center[0]};
			`RFS_A_JC2: rd_mux = {4'h0, jump_center[1]};
			`RFS_A_JC3: rd_mux = {4'h0, jump_center[2]};
			`RFS_A_JBW: rd_mux = {4'h0, jump_band_width};
			`RFS_A_STATUS: rd_mux = {14'h0000, low_torque_flag, cmd_loss_flag};
			`RFS_A_REFOUT: rd_mux = {4'h0, ref_out};
			`RFS_A_STORED: rd_mux = {4'h0, stored_ref};
			`RFS_A_F1: rd_mux = {4'h0, sampled_command_level};
			default: rd_mux = 16'h0000;
		endcase
	end

	// In save mode 1 a power cycle wins over a keypad write in the same cycle
	wire rfs_freq_t next_keypad_ref = (power_cycle && ref_save_mode) ? stored_ref :
		wr_key ? wfreq : keypad_ref;
	wire save_now = power_cycle ? !ref_save_mode : (save_key && ref_save_mode);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ref_save_mode <= 1'b0;
			src_analog <= 1'b0;
			keypad_ref <= 12'h000;
			stored_ref <= 12'h000;
			loss_fallback_ratio <= `RFS_RST_RATIO;
			low_torque_level <= `RFS_RST_LTLEVEL;
			low_torque_timer <= `RFS_RST_LTTIMER;
			base_frequency_setting <= `RFS_RST_BASEF;
			jump_band_width <= 12'h000;
			reg_rdata <= 16'h0000;
		end else begin
			if (wr_ctrl) begin
				ref_save_mode <= reg_wdata[`RFS_CTRL_SAVE_BIT];
				src_analog <= reg_wdata[`RFS_CTRL_SRC_BIT];
			end
			keypad_ref <= next_keypad_ref;
			if (save_now)
				stored_ref <= keypad_ref;
			if (wr_ratio)
				loss_fallback_ratio <= reg_wdata[9:0];
			if (wr_ltl)
				low_torque_level <= reg_wdata[10:0];
			if (wr_ltt)
				low_torque_timer <= reg_wdata;
			if (wr_base)
				base_frequency_setting <= wfreq;
			if (wr_jbw)
				jump_band_width <= wjbw;
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Millisecond time base

	logic [15:0] ms_cnt;
	wire ms_tick = ms_cnt == 16'(CYC_PER_MS - 1);
	logic [8:0] win_ms;
	wire win_tick = ms_tick && win_ms == 9'(`RFS_LOSS_WIN_MS - 1);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ms_cnt <= 16'h0000;
			win_ms <= 9'h000;
		end else begin
			ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
			if (ms_tick)
				win_ms <= win_tick ? 9'h000 : win_ms + 9'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog command loss

	// Raw level only: a filtered level would hide the very drop being looked for
	wire [15:0] raw_x10 = 16'(cmd_level) * 16'(`RFS_LOSS_PCT);
	wire [15:0] f1_x2 = 16'(sampled_command_level) * 16'(`RFS_RECOV_TENTHS);
	wire [23:0] raw_x100 = 24'(cmd_level) * 24'(`RFS_RATIO_FULL);
	wire [23:0] f1_xr = 24'(sampled_command_level) * 24'(loss_fallback_ratio);
	wire loss_seen = raw_x10 < 16'(sampled_command_level);
	wire ratio_low = loss_fallback_ratio == 10'h000 || loss_fallback_ratio == `RFS_RATIO_OFF;
	wire ratio_full = !ratio_low && loss_fallback_ratio >= `RFS_RATIO_FULL;
	wire repaired = ratio_low ? (raw_x10 > f1_x2) :
		ratio_full ? (cmd_level > sampled_command_level) :
		(raw_x100 > f1_xr);
	wire [33:0] fb_prod = 34'(f1_xr) * 34'(`RFS_DIV100_MUL);
	wire rfs_freq_t fallback_ref = fb_prod[`RFS_DIV100_SHIFT +: 12];
	wire rfs_loss_t next_loss_state = (loss_state == RFS_CMD_OK) ?
		(loss_seen ? RFS_CMD_LOST : RFS_CMD_OK) :
		(repaired ? RFS_CMD_OK : RFS_CMD_LOST);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			loss_state <= RFS_CMD_OK;
			cmd_loss_flag <= 1'b0;
			sampled_command_level <= 12'h000;
		end else begin
			loss_state <= next_loss_state;
			cmd_loss_flag <= next_loss_state == RFS_CMD_LOST;
			// Level frozen while lost so recovery is judged against the last good sample
			if (win_tick && loss_state == RFS_CMD_OK && !loss_seen)
				sampled_command_level <= cmd_level;
		end
	end

	wire use_fallback = loss_state == RFS_CMD_LOST && loss_fallback_ratio != `RFS_RATIO_OFF;
	wire rfs_freq_t src_ref = !src_analog ? keypad_ref : use_fallback ? fallback_ref : cmd_level;

	////////////////////////////////////////////////////////////////////////////
	// Jump bands

	rfs_freq_t band_lo [3];
	rfs_freq_t band_hi [3];
	logic [2:0] band_en;
	wire rfs_freq_t half_w = {1'b0, jump_band_width[11:1]};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_band
			always_ff @(posedge clk) begin
				if (!rst_b)
					jump_center[g] <= 12'h000;
				else if (reg_wr && reg_addr == 4'(`RFS_A_JC1 + g))
					jump_center[g] <= wjc;
			end
			assign band_en[g] = jump_center[g] != 12'h000 && jump_band_width != 12'h000;
			assign band_lo[g] = (jump_center[g] > half_w) ? jump_center[g] - half_w : 12'h000;
			assign band_hi[g] = jump_center[g] + half_w;
		end
	endgenerate

	// Returns {hit, merged bottom, merged top} for the band holding r
	function automatic logic [24:0] jump_merge(input rfs_freq_t r);
		logic h;
		rfs_freq_t ml;
		rfs_freq_t mh;
		h = 1'b0;
		ml = r;
		mh = r;
		for (int i = 0; i < 3; i++)
			if (band_en[i] && r >= band_lo[i] && r <= band_hi[i]) begin
				h = 1'b1;
				ml = (band_lo[i] < ml) ? band_lo[i] : ml;
				mh = (band_hi[i] > mh) ? band_hi[i] : mh;
			end
		for (int k = 0; k < 2; k++)
			for (int i = 0; i < 3; i++)
				if (h && band_en[i] && band_lo[i] <= mh && band_hi[i] >= ml) begin
					ml = (band_lo[i] < ml) ? band_lo[i] : ml;
					mh = (band_hi[i] > mh) ? band_hi[i] : mh;
				end
		return {h, ml, mh};
	endfunction

	logic [24:0] merged;
	// Procedural so a new band setting is seen even while the source value holds still
	always_comb merged = jump_merge(src_ref);
	wire band_hit = merged[24];
	wire rfs_freq_t merged_lo = merged[23:12];
	wire rfs_freq_t merged_hi = merged[11:0];
	// Coming from above holds the top, anything else holds the bottom
	wire rfs_freq_t next_ref_out = band_hit ? ((ref_out >= merged_hi) ? merged_hi : merged_lo) : src_ref;

	always_ff @(posedge clk) begin
		if (!rst_b)
			ref_out <= 12'h000;
		else
			ref_out <= next_ref_out;
	end

	////////////////////////////////////////////////////////////////////////////
	// Low torque detection

	logic [15:0] below_ms;
	logic [6:0] width_ms;
	// Torque estimate is poor at low speed, so judging stops there
	wire [14:0] out_x5 = 15'(out_freq) * 15'(`RFS_LOWF_DIV);
	wire low_freq = out_x5 < 15'(base_frequency_setting);
	wire lt_below = torque < low_torque_level;
	wire lt_above = 12'(torque) > 12'(low_torque_level) + 12'(`RFS_LT_HYST);
	wire width_done = width_ms >= 7'(`RFS_LT_MIN_MS);
	wire lt_set = !low_torque_flag && lt_below && below_ms > low_torque_timer;
	wire lt_clr = low_torque_flag && lt_above && width_done;
	wire next_lt_flag = !running ? 1'b0 : low_freq ? low_torque_flag :
		lt_set ? 1'b1 : lt_clr ? 1'b0 : low_torque_flag;
	wire [15:0] next_below_ms = !lt_below ? 16'h0000 :
		(ms_tick && below_ms != 16'hFFFF) ? below_ms + 16'h0001 : below_ms;
	wire [6:0] next_width_ms = lt_set ? 7'h00 : (ms_tick && !width_done) ? width_ms + 7'h01 : width_ms;

	always_ff @(posedge clk) begin
		if (!rst_b || !running) begin
			low_torque_flag <= 1'b0;
			below_ms <= 16'h0000;
			width_ms <= 7'h00;
		end else if (!low_freq) begin
			low_torque_flag <= next_lt_flag;
			below_ms <= next_below_ms;
			width_ms <= next_width_ms;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Pulse width lives in width_ms, so the check asks the counter instead of a long repetition
	sequence s_lt_fall;
		low_torque_flag && running ##1 !low_torque_flag;
	endsequence

	property p_stop_clears;
		!running |=> !low_torque_flag;
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("low torque flag up while stopped");

	property p_lowf_hold;
		running && low_freq |=> low_torque_flag == $past(low_torque_flag);
	endproperty
	a_lowf_hold: assert property (p_lowf_hold) else $error("low torque flag moved at low frequency");

	property p_min_width;
		s_lt_fall |-> $past(width_done);
	endproperty
	a_min_width: assert property (p_min_width) else $error("low torque pulse too short");

	property p_hyst;
		low_torque_flag && running && !low_freq && !lt_above |=> low_torque_flag;
	endproperty
	a_hyst: assert property (p_hyst) else $error("low torque flag fell inside hysteresis");

	property p_loss_detect;
		loss_state == RFS_CMD_OK && loss_seen |=> cmd_loss_flag;
	endproperty
	a_loss_detect: assert property (p_loss_detect) else $error("command loss not flagged");

	property p_off_follows;
		src_analog && cmd_loss_flag && loss_fallback_ratio == `RFS_RATIO_OFF && !band_hit
			|=> ref_out == $past(cmd_level);
	endproperty
	a_off_follows: assert property (p_off_follows) else $error("reference changed with ratio off");

	property p_auto_save;
		power_cycle && !ref_save_mode |=> stored_ref == $past(keypad_ref);
	endproperty
	a_auto_save: assert property (p_auto_save) else $error("auto save missed");

	property p_key_restore;
		power_cycle && ref_save_mode |=> keypad_ref == $past(stored_ref);
	endproperty
	a_key_restore: assert property (p_key_restore) else $error("stored reference not restored");

	property p_band_hold;
		band_hit |=> ref_out == $past(merged_lo) || ref_out == $past(merged_hi);
	endproperty
	a_band_hold: assert property (p_band_hold) else $error("reference left inside jump band");
endmodule

// file: core/rfs_map.svh
// Constants of the reference frequency supervisor: register offsets, reset values, scaling and timing.
// Assumes frequencies in 0.1 Hz steps, torque and levels in 0.1 % steps, ratio in whole percent.
`ifndef RFS_MAP_SVH
`define RFS_MAP_SVH
`define RFS_A_CTRL 4'h0
`define RFS_A_KEYREF 4'h1
`define RFS_A_RATIO 4'h2
`define RFS_A_LTLEVEL 4'h3
`define RFS_A_LTTIMER 4'h4
`define RFS_A_BASEF 4'h5
`define RFS_A_JC1 4'h6
`define RFS_A_JC2 4'h7
`define RFS_A_JC3 4'h8
`define RFS_A_JBW 4'h9
`define RFS_A_STATUS 4'hA
`define RFS_A_REFOUT 4'hB
`define RFS_A_STORED 4'hC
`define RFS_A_F1 4'hD
`define RFS_CTRL_SAVE_BIT 0
`define RFS_CTRL_SRC_BIT 1
`define RFS_RST_RATIO 10'h000
`define RFS_RST_LTLEVEL 11'h0C8
`define RFS_RST_LTTIMER 16'h0014
`define RFS_RST_BASEF 12'h1F4
`define RFS_LOSS_DIV 12
`define RFS_LOSS_PCT 4'hA
`define RFS_RECOV_TENTHS 4'h2
`define RFS_RATIO_OFF 10'h3E7
`define RFS_RATIO_FULL 10'h064
`define RFS_DIV100_MUL 11'h51F
`define RFS_DIV100_SHIFT 17
`define RFS_LT_HYST 11'h032
`define RFS_LOWF_DIV 3'h5
`define RFS_CLK_HZ 40000000
`define RFS_LOSS_WIN_MS 400
`define RFS_LT_MIN_MS 100
`define RFS_JUMP_MAX 12'h4B0
`define RFS_JBW_MAX 12'h12C
`endif

// file: core/rfs_pkg.sv
// Types shared by the reference frequency supervisor.
// Assumes rfs_map.svh supplies all numeric constants.
package rfs_pkg;
	typedef logic [11:0] rfs_freq_t;
	typedef logic [15:0] rfs_word_t;
	typedef enum logic {RFS_CMD_OK, RFS_CMD_LOST} rfs_loss_t;
endpackage

// file: verif/rfs_cmd_src.sv
// Partner model: analog frequency command source and the keypad keys.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
module rfs_cmd_src (
	input wire logic clk,
	output rfs_pkg::rfs_freq_t cmd_level,
	output logic save_key,
	output logic power_cycle
);
	import rfs_pkg::*;
	initial begin
		cmd_level = 12'h000;
		save_key = 1'b0;
		power_cycle = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Steps rather than ramps: the harshest case for the loss detector
	task automatic set_level(input rfs_freq_t v);
		@(posedge clk);
		cmd_level <= v;
	endtask
	// One-cycle key or power event
	task automatic pulse(input logic pwr);
		@(posedge clk);
		if (pwr) begin
			power_cycle <= 1'b1;
		end else begin
			save_key <= 1'b1;
		end
		@(posedge clk);
		power_cycle <= 1'b0;
		save_key <= 1'b0;
	endtask
endmodule

// file: verif/rfs_top_test.sv
// Self-checking bench of the reference frequency supervisor.
// Assumes CYC_PER_MS of 10, so a sampling window is 4000 cycles.
`timescale 1ns/1ps
`include "rfs_map.svh"
module rfs_top_test;
	import rfs_pkg::*;
	logic clk, rst_b, reg_wr, reg_rd, running;
	logic [3:0] reg_addr;
	rfs_word_t reg_wdata, reg_rdata;
	logic [10:0] torque;
	rfs_freq_t cmd_level, out_freq, ref_out;
	logic save_key, power_cycle, cmd_loss_flag, low_torque_flag;
	int err_total = 0;
	int n_compared = 0;
	logic [31:0] lfsr = 32'h9621;
	int jc[3];
	int jw, prev, v, e, r, thr;
	int ratios[4] = '{50, 999, 150, 0};
	rfs_top #(.CYC_PER_MS(10)) i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_level(cmd_level), .torque(torque),
		.out_freq(out_freq), .running(running), .save_key(save_key), .power_cycle(power_cycle),
		.ref_out(ref_out), .cmd_loss_flag(cmd_loss_flag), .low_torque_flag(low_torque_flag));
	rfs_cmd_src src (.clk(clk), .cmd_level(cmd_level), .save_key(save_key), .power_cycle(power_cycle));
	////////////////////////////////////////////////////////////////
	task automatic chk_word(input string what, input int exp, input rfs_word_t got);
		n_compared++;
		if (got !== 16'(exp)) begin
			err_total++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input int d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= 16'(d);
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input int exp, input string what);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk_word(what, exp, reg_rdata);
	endtask
	task automatic drv(input logic run, input int t, input int f);
		@(posedge clk);
		running <= run;
		torque <= 11'(t);
		out_freq <= 12'(f);
	endtask
	// Bounded wait: a stuck flag shows up as a mismatch, not a hang
	task automatic wait_lt(input logic val, input int lim);
		int n;
		n = 0;
		while (low_torque_flag !== val && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	function automatic int jump(input int p, input int x);
		int lo[3], hi[3];
		int l, h, k;
		l = -1;
		h = -1;
		for (k = 0; k < 3; k++) begin
			lo[k] = (jc[k] < jw / 2) ? 0 : jc[k] - jw / 2;
			hi[k] = jc[k] + jw / 2;
			if (jc[k] != 0 && jw != 0 && x >= lo[k] && x <= hi[k]) begin
				l = lo[k];
				h = hi[k];
			end
		end
		if (l < 0) begin
			return x;
		end
		repeat (3) for (k = 0; k < 3; k++) begin
			if (jc[k] != 0 && lo[k] <= h && hi[k] >= l) begin
				l = (lo[k] < l) ? lo[k] : l;
				h = (hi[k] > h) ? hi[k] : h;
			end
		end
		return (p >= h) ? h : l;
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		summarize();
	end
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		torque = 11'h000;
		out_freq = 12'h1F4;
		running = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd(`RFS_A_RATIO, `RFS_RST_RATIO, "ratio");
		rd(`RFS_A_LTLEVEL, `RFS_RST_LTLEVEL, "lt_level");
		rd(`RFS_A_LTTIMER, `RFS_RST_LTTIMER, "lt_timer");
		rd(`RFS_A_BASEF, `RFS_RST_BASEF, "base_freq");
		wr(`RFS_A_STATUS, 3);
		rd(`RFS_A_STATUS, 0, "status");
		rd(4'hE, 0, "unmapped");
		$display("test reset done");
		wr(`RFS_A_KEYREF, 300);
		src.pulse(1'b1);
		rd(`RFS_A_STORED, 300, "stored");
		chk_word("ref_out", 300, {4'h0, ref_out});
		wr(`RFS_A_CTRL, 1);
		wr(`RFS_A_KEYREF, 400);
		src.pulse(1'b0);
		rd(`RFS_A_STORED, 400, "stored");
		wr(`RFS_A_KEYREF, 450);
		src.pulse(1'b1);
		cyc(3);
		rd(`RFS_A_KEYREF, 400, "keyref");
		chk_word("ref_out", 400, {4'h0, ref_out});
		$display("test save done");
		wr(`RFS_A_CTRL, 2);
		foreach (ratios[i]) begin
			r = ratios[i];
			wr(`RFS_A_RATIO, r);
			src.set_level(12'd500);
			cyc(4100);
			rd(`RFS_A_F1, 500, "sampled_level");
			src.set_level(12'd40);
			cyc(3);
			chk_bit("loss", 1'b1, cmd_loss_flag);
			chk_word("ref_out", (r == 999) ? 40 : (500 * r * 1311) >>> 17, {4'h0, ref_out});
			thr = (r == 0 || r == 999) ? 100 : (r >= 100) ? 500 : 500 * r / 100;
			src.set_level(12'(thr));
			cyc(3);
			chk_bit("loss", 1'b1, cmd_loss_flag);
			src.set_level(12'(thr + 1));
			cyc(3);
			chk_bit("loss", 1'b0, cmd_loss_flag);
			chk_word("ref_out", thr + 1, {4'h0, ref_out});
		end
		$display("test loss done");
		wr(`RFS_A_LTLEVEL, 1000);
		wr(`RFS_A_LTTIMER, 3);
		drv(1'b1, 900, 500);
		cyc(25);
		chk_bit("low_torque", 1'b0, low_torque_flag);
		wait_lt(1'b1, 40);
		chk_bit("low_torque", 1'b1, low_torque_flag);
		drv(1'b1, 1040, 500);
		cyc(1500);
		chk_bit("low_torque", 1'b1, low_torque_flag);
		drv(1'b1, 1051, 500);
		cyc(5);
		chk_bit("low_torque", 1'b0, low_torque_flag);
		drv(1'b1, 900, 500);
		wait_lt(1'b1, 60);
		drv(1'b1, 1100, 500);
		cyc(900);
		chk_bit("low_torque", 1'b1, low_torque_flag);
		wait_lt(1'b0, 250);
		chk_bit("low_torque", 1'b0, low_torque_flag);
		drv(1'b1, 900, 500);
		wait_lt(1'b1, 60);
		drv(1'b1, 1100, 90);
		cyc(1500);
		chk_bit("low_torque", 1'b1, low_torque_flag);
		drv(1'b0, 1100, 90);
		cyc(2);
		chk_bit("low_torque", 1'b0, low_torque_flag);
		$display("test low torque done");
		wr(`RFS_A_CTRL, 0);
		wr(`RFS_A_JC3, 1300);
		rd(`RFS_A_JC3, `RFS_JUMP_MAX, "center_three");
		wr(`RFS_A_JBW, 400);
		rd(`RFS_A_JBW, `RFS_JBW_MAX, "band_width");
		jc = '{300, 340, 0};
		jw = 60;
		wr(`RFS_A_JC1, 300);
		wr(`RFS_A_JC2, 340);
		wr(`RFS_A_JC3, 0);
		wr(`RFS_A_JBW, 60);
		prev = 400;
		repeat (24) begin
			lfsr = lfsr_next(lfsr);
			v = 240 + int'(lfsr % 160);
			// Torque always above level plus hysteresis, so no run state may raise the flag
			drv(lfsr[5], 1051 + int'(lfsr[26:18]), int'(lfsr[17:6]));
			wr(`RFS_A_KEYREF, v);
			cyc(3);
			e = jump(prev, v);
			chk_word("ref_out", e, {4'h0, ref_out});
			chk_bit("low_torque", 1'b0, low_torque_flag);
			prev = e;
		end
		wr(`RFS_A_JBW, 0);
		wr(`RFS_A_KEYREF, 300);
		cyc(3);
		chk_word("ref_out", 300, {4'h0, ref_out});
		$display("test jump done");
		summarize();
	end
endmodule
